// file: design/mcr_params.svh
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH
`define MCR_CTRL_OFFSET      8'h00
`define MCR_STATUS_OFFSET    8'h04
`define MCR_FLOW_OFFSET      8'h08
`define MCR_DUPLEX_BIT       0
`define MCR_LOOPBACK_BIT     1
`define MCR_RXBUF_FLOW_BIT   3
`define MCR_TXFLOW_BIT       4
`define MCR_MEDIA_IF_ENABLE_BIT        5
`define MCR_TX_PACING_EN_BIT       6
`define MCR_ARB_BIT          9
`define MCR_IDLE_REQ_BIT     11
`define MCR_RXFIFO_FLOW_BIT  12
`define MCR_OWNER_BIT        13
`define MCR_LEN_BLOCK_BIT    14
`define MCR_CTRL_MASK        32'h0000_7a7b
`define MCR_CTRL_RESET       32'h0000_0000
`define MCR_IDLE_STAT_BIT    31
`define MCR_FLOW_TRIG_BIT    0
`define MCR_IDLE_CYCLES      4'h4
`endif

// file: design/mcr_pkg.sv
package mcr_pkg;
	typedef struct packed {
		logic       len_block;
		logic       owner_value;
		logic       rx_fifo_flow_en;
		logic       idle_request;
		logic       arb_fixed;
		logic       pacing_en;
		logic       media_if_enable;
		logic       duplex_select;
	} mcr_ctrl_type;

	typedef struct packed {
		logic       valid;
		logic [2:0] channel;
	} mcr_grant_type;

	typedef enum logic [2:0] {
		MCR_BUSY    = 3'b001,
		MCR_DRAIN   = 3'b010,
		MCR_IDLE    = 3'b100
	} mcr_idle_state_type;
endpackage

// file: design/mcr_tx_arbiter.sv
`timescale 1ns/10ps
module mcr_tx_arbiter #(
	parameter int CHANNELS = 8
) (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic                     clk_en,
	input  wire logic                     fixed_prio,
	input  wire logic [CHANNELS-1:0]      request,
	input  wire logic                     advance,
	output mcr_pkg::mcr_grant_type        grant
);
	logic [2:0] last_q;
	logic [2:0] last_d;

	function automatic mcr_pkg::mcr_grant_type pick(input logic [CHANNELS-1:0] req,
			input logic fixed, input logic [2:0] last);
		mcr_pkg::mcr_grant_type g;
		logic [2:0] idx;
		g = '0;
		if (fixed) begin
			// Highest channel wins
			for (int i = 0; i < CHANNELS; i++) begin
				if (req[i]) begin
					g.valid = 1'b1;
					g.channel = 3'(i);
				end
			end
		end else begin
			// Rotate starting after the last served channel
			for (int k = CHANNELS; k >= 1; k--) begin
				idx = 3'((32'(last) + 32'(k)) % CHANNELS);
				if (req[idx]) begin
					g.valid = 1'b1;
					g.channel = idx;
				end
			end
		end
		return g;
	endfunction

	always_comb begin
		grant = pick(request, fixed_prio, last_q);
		last_d = last_q;
		if (advance && grant.valid) begin
			last_d = grant.channel;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			last_q <= 3'h7;
		end else if (clk_en) begin
			last_q <= last_d;
		end
	end
endmodule

// file: design/mcr_mac_control.sv
// Summary of operation
// - Length-block bit set suppresses DMA writes of descriptor word three.
// - End of packet writes descriptor ownership flag with the control bit value.
// - Full duplex with FIFO flow enable and media interface enable sends pause frames on flow trigger.
// - Idle request commands idle; software polls status idle flag.
// - Arbitration bit zero selects round-robin transmit channel choice.
// - Arbitration bit one selects fixed priority, channel seven highest.
// - Transmit pacing active only while pacing enable is one.
// - Media interface enable zero holds receive and transmit paths in reset.
// - Status idle flag reads zero in reset, one a clock later while the MAC is not busy.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "mcr_params.svh"
module mcr_mac_control #(
	parameter int CHANNELS = 8
) (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic [31:0]                reg_rdata,
	input  wire logic                  rx_eop,
	input  wire logic                  rx_desc_len_wr_req,
	input  wire logic                  rx_flow_trigger,
	input  wire logic                  mac_busy,
	input  wire logic [CHANNELS-1:0]   tx_chan_request,
	input  wire logic                  tx_chan_advance,
	output logic                       rx_desc_len_wr_en,
	output logic                       rx_owner_wr_strobe,
	output logic                       rx_owner_wr_value,
	output logic                       pause_frame_req,
	output logic                       mac_idle,
	output logic                       tx_grant_valid,
	output logic [2:0]                 tx_grant_channel,
	output logic                       tx_pacing_active,
	output logic                       mii_rx_reset,
	output logic                       mii_tx_reset,
	output logic                       loopback_en,
	output logic                       duplex_full
);
	logic [31:0]                 ctrl_q;
	logic [31:0]                 ctrl_d;
	logic [31:0]                 rdata_q;
	logic [31:0]                 rdata_d;
	logic                        idle_q;
	logic                        idle_d;
	logic [3:0]                  drain_q;
	logic [3:0]                  drain_d;
	mcr_pkg::mcr_idle_state_type state_q;
	mcr_pkg::mcr_idle_state_type state_d;
	logic                        len_en_q;
	logic                        len_en_d;
	logic                        own_stb_q;
	logic                        own_stb_d;
	logic                        own_val_q;
	logic                        own_val_d;
	logic                        pause_q;
	logic                        pause_d;
	logic                        pace_q;
	logic                        pace_d;
	logic                        mii_rst_q;
	logic                        mii_rst_d;
	logic                        loop_q;
	logic                        loop_d;
	logic                        dup_q;
	logic                        dup_d;
	mcr_pkg::mcr_grant_type      grant_q;
	mcr_pkg::mcr_grant_type      grant_d;
	mcr_pkg::mcr_grant_type      arb_grant;
	mcr_pkg::mcr_ctrl_type       ctl;

	mcr_tx_arbiter #(
		.CHANNELS (CHANNELS)
	) mcr_tx_arbiter_inst (
		.clock      (clock),
		.rst_n      (rst_n),
		.clk_en     (clk_en),
		.fixed_prio (ctl.arb_fixed),
		.request    (tx_chan_request),
		.advance    (tx_chan_advance),
		.grant      (arb_grant)
	);

	always_comb begin
		ctl.len_block       = ctrl_q[`MCR_LEN_BLOCK_BIT];
		ctl.owner_value     = ctrl_q[`MCR_OWNER_BIT];
		ctl.rx_fifo_flow_en = ctrl_q[`MCR_RXFIFO_FLOW_BIT];
		ctl.idle_request    = ctrl_q[`MCR_IDLE_REQ_BIT];
		ctl.arb_fixed       = ctrl_q[`MCR_ARB_BIT];
		ctl.pacing_en       = ctrl_q[`MCR_TX_PACING_EN_BIT];
		ctl.media_if_enable = ctrl_q[`MCR_MEDIA_IF_ENABLE_BIT];
		ctl.duplex_select   = ctrl_q[`MCR_DUPLEX_BIT];
	end

	// Register file
	always_comb begin
		ctrl_d = ctrl_q;
		rdata_d = 32'h0000_0000;
		if (reg_write && reg_addr == `MCR_CTRL_OFFSET) begin
			// Reserved bits dropped so they always read zero
			ctrl_d = reg_wdata & `MCR_CTRL_MASK;
		end
		if (reg_read) begin
			case (reg_addr)
				`MCR_CTRL_OFFSET: begin
					rdata_d = ctrl_q;
				end
				`MCR_STATUS_OFFSET: begin
					rdata_d[`MCR_IDLE_STAT_BIT] = mac_idle;
				end
				`MCR_FLOW_OFFSET: begin
					rdata_d[`MCR_FLOW_TRIG_BIT] = rx_flow_trigger;
				end
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	// Idle sequencing; idle shows once traffic is quiet, and the drain must end before idle holds while busy
	always_comb begin
		state_d = state_q;
		drain_d = drain_q;
		case (state_q)
			mcr_pkg::MCR_BUSY: begin
				if (ctl.idle_request) begin
					state_d = mcr_pkg::MCR_DRAIN;
					drain_d = `MCR_IDLE_CYCLES;
				end
			end
			mcr_pkg::MCR_DRAIN: begin
				if (!ctl.idle_request) begin
					state_d = mcr_pkg::MCR_BUSY;
				end else if (mac_busy) begin
					drain_d = `MCR_IDLE_CYCLES;
				end else if (drain_q == 4'h0) begin
					state_d = mcr_pkg::MCR_IDLE;
				end else begin
					drain_d = drain_q - 4'h1;
				end
			end
			mcr_pkg::MCR_IDLE: begin
				if (!ctl.idle_request) begin
					state_d = mcr_pkg::MCR_BUSY;
				end
			end
			default: begin
				state_d = mcr_pkg::MCR_BUSY;
			end
		endcase
		// Quiet traffic also counts, so the flag rises one clock after reset
		idle_d = (state_d == mcr_pkg::MCR_IDLE) || !mac_busy;
	end

	// Flop keeps the flag low through reset and glitch free on the status word
	assign mac_idle = idle_q;

	// Datapath controls
	always_comb begin
		len_en_d  = rx_desc_len_wr_req && !ctl.len_block;
		own_stb_d = rx_eop;
		own_val_d = ctl.owner_value;
		pause_d   = rx_flow_trigger && ctl.rx_fifo_flow_en
			&& (ctl.duplex_select || ctrl_q[`MCR_LOOPBACK_BIT]) && ctl.media_if_enable;
		pace_d    = ctl.pacing_en;
		mii_rst_d = !ctl.media_if_enable;
		loop_d    = ctrl_q[`MCR_LOOPBACK_BIT];
		dup_d     = ctl.duplex_select || ctrl_q[`MCR_LOOPBACK_BIT];
		grant_d   = arb_grant;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_q    <= `MCR_CTRL_RESET;
			rdata_q   <= 32'h0000_0000;
			idle_q    <= 1'b0;
			drain_q   <= 4'h0;
			state_q   <= mcr_pkg::MCR_BUSY;
			len_en_q  <= 1'b0;
			own_stb_q <= 1'b0;
			own_val_q <= 1'b0;
			pause_q   <= 1'b0;
			pace_q    <= 1'b0;
			mii_rst_q <= 1'b1;
			loop_q    <= 1'b0;
			dup_q     <= 1'b0;
			grant_q   <= '0;
		end else if (clk_en) begin
			ctrl_q    <= ctrl_d;
			rdata_q   <= rdata_d;
			idle_q    <= idle_d;
			drain_q   <= drain_d;
			state_q   <= state_d;
			len_en_q  <= len_en_d;
			own_stb_q <= own_stb_d;
			own_val_q <= own_val_d;
			pause_q   <= pause_d;
			pace_q    <= pace_d;
			mii_rst_q <= mii_rst_d;
			loop_q    <= loop_d;
			dup_q     <= dup_d;
			grant_q   <= grant_d;
		end
	end

	assign reg_rdata          = rdata_q;
	assign rx_desc_len_wr_en  = len_en_q;
	assign rx_owner_wr_strobe = own_stb_q;
	assign rx_owner_wr_value  = own_val_q;
	assign pause_frame_req    = pause_q;
	assign tx_grant_valid     = grant_q.valid;
	assign tx_grant_channel   = grant_q.channel;
	assign tx_pacing_active   = pace_q;
	assign mii_rx_reset       = mii_rst_q;
	assign mii_tx_reset       = mii_rst_q;
	assign loopback_en        = loop_q;
	assign duplex_full        = dup_q;
endmodule

// file: tb/mcr_mac_control_sva.sv
`timescale 1ns/10ps
module mcr_mac_control_sva #(
	parameter int CHANNELS = 8
) (
	input wire logic		clock,
	input wire logic		rst_n,
	input wire logic [7:0]		reg_addr,
	input wire logic [31:0]		reg_wdata,
	input wire logic		reg_write,
	input wire logic		reg_read,
	input wire logic [31:0]		reg_rdata,
	input wire logic		rx_eop,
	input wire logic		rx_desc_len_wr_req,
	input wire logic		rx_flow_trigger,
	input wire logic		mac_busy,
	input wire logic [CHANNELS-1:0]	tx_chan_request,
	input wire logic		rx_desc_len_wr_en,
	input wire logic		rx_owner_wr_strobe,
	input wire logic		rx_owner_wr_value,
	input wire logic		pause_frame_req,
	input wire logic		mac_idle,
	input wire logic		tx_grant_valid,
	input wire logic [2:0]		tx_grant_channel,
	input wire logic		tx_pacing_active,
	input wire logic		mii_rx_reset
);
	// Shadow of the control word, kept from the bus alone
	logic [31:0]	sh_q;
	logic [31:0]	sh_d;
	function automatic logic [2:0] top_ch(logic [CHANNELS-1:0] r);
		top_ch = 3'h0;
		for (int i = 0; i < CHANNELS; i++)
			if (r[i])
				top_ch = 3'(i);
	endfunction
	always_comb begin
		sh_d = sh_q;
		if (reg_write && reg_addr == 8'h00)
			sh_d = reg_wdata & 32'h0000_7a7b;
		if (!rst_n)
			sh_d = 32'h0;
	end
	always_ff @(posedge clock) begin
		sh_q <= sh_d;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_len_block: assert property ($past(rst_n) |->
		rx_desc_len_wr_en == ($past(rx_desc_len_wr_req) && !$past(sh_q[14])))
		else $error("len write gate wrong");
	a_owner_write: assert property ($past(rst_n) |->
		rx_owner_wr_strobe == $past(rx_eop) && rx_owner_wr_value == $past(sh_q[13]))
		else $error("owner write wrong");
	a_pause_gate: assert property ($past(rst_n) |-> pause_frame_req ==
		$past(rx_flow_trigger && sh_q[12] && (sh_q[0] || sh_q[1]) && sh_q[5]))
		else $error("pause request wrong");
	a_pacing_follow: assert property ($past(rst_n) |->
		tx_pacing_active == $past(sh_q[6])) else $error("pacing wrong");
	a_mii_hold: assert property ($past(rst_n) |->
		mii_rx_reset == !$past(sh_q[5])) else $error("media reset wrong");
	a_idle_quiet: assert property ($past(rst_n) && !$past(mac_busy) |-> mac_idle)
		else $error("idle flag low while quiet");
	a_idle_reset: assert property (!$past(rst_n) |-> !mac_idle)
		else $error("idle flag high straight out of reset");
	a_rdata_zero: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
	a_ctrl_readback: assert property ($past(reg_read) && $past(reg_addr) == 8'h00
		|-> reg_rdata == $past(sh_q)) else $error("control readback wrong");
	a_fixed_grant: assert property ($past(rst_n) && $past(sh_q[9]) &&
		$past(|tx_chan_request) |-> tx_grant_valid && tx_grant_channel ==
		top_ch($past(tx_chan_request))) else $error("fixed grant wrong");
	c_pause: cover property (pause_frame_req);
	c_top_grant: cover property (tx_grant_valid && tx_grant_channel == 3'h7);
	c_idle: cover property ($rose(mac_idle));
endmodule
bind mcr_mac_control mcr_mac_control_sva #(.CHANNELS(CHANNELS)) mcr_mac_control_sva_inst (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_eop(rx_eop),
	.rx_desc_len_wr_req(rx_desc_len_wr_req), .rx_flow_trigger(rx_flow_trigger),
	.mac_busy(mac_busy), .tx_chan_request(tx_chan_request),
	.rx_desc_len_wr_en(rx_desc_len_wr_en), .rx_owner_wr_strobe(rx_owner_wr_strobe),
	.rx_owner_wr_value(rx_owner_wr_value), .pause_frame_req(pause_frame_req),
	.mac_idle(mac_idle), .tx_grant_valid(tx_grant_valid),
	.tx_grant_channel(tx_grant_channel), .tx_pacing_active(tx_pacing_active),
	.mii_rx_reset(mii_rx_reset));

// file: tb/mcr_mac_control_test.sv
`timescale 1ns/10ps
module mcr_mac_control_test;
	logic		clock = 1'b0;
	logic		rst_n = 1'b0;
	logic [7:0]	reg_addr = 8'h00;
	logic [31:0]	reg_wdata = 32'h0;
	logic		reg_write = 1'b0;
	logic		reg_read = 1'b0;
	logic [31:0]	reg_rdata;
	logic		len_req = 1'b0;
	logic		eop = 1'b0;
	logic		trig = 1'b0;
	logic		busy = 1'b0;
	logic [7:0]	chan_req = 8'h00;
	logic		adv = 1'b0;
	logic		len_en, own_stb, own_val, pause, idle, g_valid, pace, mrx, mtx, lpb, dup;
	logic [2:0]	g_ch;
	int		err_count = 0;
	int		cmp_count = 0;
	always #5 clock = ~clock;
	mcr_mac_control #(.CHANNELS(8)) mcr_mac_control_inst (
		.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .rx_eop(eop), .rx_desc_len_wr_req(len_req),
		.rx_flow_trigger(trig), .mac_busy(busy), .tx_chan_request(chan_req),
		.tx_chan_advance(adv), .rx_desc_len_wr_en(len_en), .rx_owner_wr_strobe(own_stb),
		.rx_owner_wr_value(own_val), .pause_frame_req(pause), .mac_idle(idle),
		.tx_grant_valid(g_valid), .tx_grant_channel(g_ch), .tx_pacing_active(pace),
		.mii_rx_reset(mrx), .mii_tx_reset(mtx), .loopback_en(lpb), .duplex_full(dup));
	task automatic test_done();
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata & m, e);
	endtask
	// Bounded poll; a stuck flag counts as a mismatch
	task automatic wait_idle(logic e);
		int i;
		i = 0;
		while (idle !== e && i < 40) begin
			step(1);
			i++;
		end
		chk({31'h0, idle}, {31'h0, e});
		if (idle !== e)
			test_done();
	endtask
	initial begin
		logic b;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		step(2);
		rd(8'h00, 32'hffff_ffff, 32'h0);
		rd(8'h04, 32'h8000_0000, 32'h8000_0000);
		rd(8'h40, 32'hffff_ffff, 32'h0);
		// Loopback follows its bit whether or not the media interface is held off
		wr(8'h00, 32'h0000_7a5b);
		rd(8'h00, 32'hffff_ffff, 32'h0000_7a5b);
		chk({27'h0, pace, mrx, mtx, lpb, dup}, 32'h0000_001f);
		wr(8'h00, 32'h0000_7a7b);
		rd(8'h00, 32'hffff_ffff, 32'h0000_7a7b);
		chk({27'h0, pace, mrx, mtx, lpb, dup}, 32'h0000_0013);
		wr(8'h00, 32'h0000_0002);
		wr(8'h00, 32'h0);
		step(1);
		chk({27'h0, pace, mrx, mtx, lpb, dup}, 32'h0000_000c);
		for (int v = 0; v < 2; v++) begin
			b = (v != 0);
			wr(8'h00, (b ? 32'h0000_7000 : 32'h0) | 32'h0000_0021);
			len_req <= 1'b1;
			eop <= 1'b1;
			trig <= 1'b1;
			@(posedge clock);
			len_req <= 1'b0;
			eop <= 1'b0;
			trig <= 1'b0;
			#1;
			chk({28'h0, len_en, own_stb, own_val, pause}, {28'h0, ~b, 1'b1, b, b});
		end
		@(posedge clock);
		busy <= 1'b1;
		step(2);
		chk({31'h0, idle}, 32'h0);
		wr(8'h00, 32'h0000_0800);
		@(posedge clock);
		busy <= 1'b0;
		wait_idle(1'b1);
		rd(8'h04, 32'h8000_0000, 32'h8000_0000);
		// Drain must finish before traffic returns, or the flag drops again
		repeat (3) @(posedge clock);
		busy <= 1'b1;
		step(2);
		chk({31'h0, idle}, 32'h1);
		wr(8'h00, 32'h0);
		wait_idle(1'b0);
		// Fixed order first so the rotation pointer is untouched
		wr(8'h00, 32'h0000_0200);
		chan_req <= 8'h81;
		step(2);
		chk({28'h0, g_valid, g_ch}, 32'h0000_000f);
		@(posedge clock);
		chan_req <= 8'h06;
		step(2);
		chk({28'h0, g_valid, g_ch}, 32'h0000_000a);
		wr(8'h00, 32'h0);
		chan_req <= 8'hff;
		step(2);
		chk({28'h0, g_valid, g_ch}, 32'h0000_0008);
		@(posedge clock);
		adv <= 1'b1;
		@(posedge clock);
		adv <= 1'b0;
		step(1);
		chk({28'h0, g_valid, g_ch}, 32'h0000_0009);
		// Flow status word follows the trigger in the read slot
		@(posedge clock);
		trig <= 1'b1;
		rd(8'h08, 32'h0000_0001, 32'h0000_0001);
		test_done();
	end
endmodule
